/* src/nev_sequencer.sv */
// erase-verify sequencer top: command launch, blank-check scan over the
// array read port, status and fault flags.
// assumes a synchronous array read port answering with one valid pulse
// per request, and software strobes synchronous to clk_i.
//
// Operation
// RQ1 - program/erase launch before divider init sets access error, no run
// RQ2 - undefined command code sets access error, command not run
// RQ3 - read of busy block returns invalid data once both fault flags set
// RQ4 - read of busy block sets both single and double fault flags
// RQ5 - software clears access error and protection flags before launching
// RQ6 - software programs only erased bytes or longwords, never cumulatively
// RQ7 - code 01 checks all blocks; index other than 000 errors
// RQ8 - launch clears complete flag; it sets again when verify finishes
// RQ9 - all-blocks check finding unerased location sets both verify bits
// RQ10 - read error sets bit1, uncorrectable sets bit0; no protection flag
// RQ11 - block verify: code and address high at 000, address low at 001
// RQ12 - address bit 23 selects flash (0) or eeprom (1) block
// RQ13 - failed block blank check sets both verify bits at completion
// RQ14 - block and section verify error on address outside valid regions
// RQ15 - section verify: code, address at 000 and 001, count at 010
// RQ16 - section verify with index other than 010 sets access error
// RQ17 - section verify with unaligned start address sets access error
// RQ18 - section running past flash boundary sets access error
// RQ19 - section verify not allowed in current mode sets access error
// RQ20 - unerased longword in section sets both verify bits at completion
// RQ21 - command object index selects the byte pair software accesses
`timescale 1ns/1ns
module nev_sequencer (
   input wire logic clk_i, // 25 MHz clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic idx_wr_i, // write command_object_index
   input wire logic [2:0] idx_data_i, // index value
   input wire logic hi_wr_i, // write command_object_high
   input wire logic lo_wr_i, // write command_object_low
   input wire logic [7:0] cob_wdata_i, // byte to write
   output logic [15:0] cob_rdata_o, // pair at current index
   input wire logic command_complete_flag_clr_i, // launch: clear complete flag
   input wire logic err_clr_i, // clear access/protection flags
   input wire logic [1:0] fault_clr_i, // clear double, single fault
   input wire logic div_init_i, // nvm_clock_divider written
   input wire logic mode_ok_i, // section verify allowed
   input nev_pkg::nev_rd_s rd_i, // array read answer
   output logic rd_req_o, // array read request level
   output logic [23:0] rd_addr_o, // longword address
   input wire logic cpu_rd_i, // cpu read of array
   input wire logic [23:0] cpu_addr_i, // cpu read address
   output logic cpu_invalid_o, // cpu read returned invalid data
   output logic command_complete_flag_o, // idle, ready for launch
   output logic access_error_flag_o, // sticky access error
   output logic protection_violation_flag_o, // never set here
   output logic [1:0] verify_status_bits_o, // bit1 any, bit0 uncorr
   output logic single_fault_detect_flag_o, // sticky
   output logic double_fault_detect_flag_o // sticky
);
   nev_pkg::nev_state_e state_reg;
   nev_pkg::nev_cob_s cob;
   logic [23:0] end_reg;
   logic two_phase_reg;
   logic tgt_flash_reg;
   logic tgt_ee_reg;
   logic launch;
   logic chk_err;
   logic chk_verify;
   logic chk_two;
   logic chk_flash;
   logic chk_ee;
   logic [23:0] chk_start;
   logic [23:0] chk_end;
   logic rd_done;
   logic [23:0] addr_next;
   logic last_lw;
   logic conflict;

   nev_cmd_object u_cob (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .lock_i(!command_complete_flag_o),
      .idx_wr_i(idx_wr_i),
      .idx_data_i(idx_data_i),
      .hi_wr_i(hi_wr_i),
      .lo_wr_i(lo_wr_i),
      .wdata_i(cob_wdata_i),
      .rdata_o(cob_rdata_o),
      .cob_o(cob)
   );

   nev_launch_check u_chk (
      .cob_i(cob),
      .div_init_i(div_init_i),
      .mode_ok_i(mode_ok_i),
      .err_o(chk_err),
      .verify_o(chk_verify),
      .two_phase_o(chk_two),
      .tgt_flash_o(chk_flash),
      .tgt_ee_o(chk_ee),
      .start_o(chk_start),
      .end_o(chk_end)
   );

   // a launch with a pending error flag is ignored, not flagged again
   assign launch = command_complete_flag_clr_i && command_complete_flag_o &&
                   state_reg == nev_pkg::ST_IDLE &&
                   !access_error_flag_o &&
                   !protection_violation_flag_o; // RQ5
   assign rd_done = state_reg == nev_pkg::ST_READ && rd_i.valid;
   assign addr_next = rd_addr_o + nev_pkg::LW_STEP;
   assign last_lw = addr_next == end_reg;
   assign conflict = cpu_rd_i && state_reg != nev_pkg::ST_IDLE &&
                     ((tgt_flash_reg && !cpu_addr_i[nev_pkg::SEL_BIT]) ||
                      (tgt_ee_reg && cpu_addr_i[nev_pkg::SEL_BIT]));

   // scan state and address walk
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= nev_pkg::ST_IDLE;
         rd_addr_o <= nev_pkg::FLASH_BASE;
         end_reg <= nev_pkg::FLASH_BASE;
         two_phase_reg <= 1'b0;
         tgt_flash_reg <= 1'b0;
         tgt_ee_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            nev_pkg::ST_IDLE: begin
               if (launch && !chk_err) begin
                  rd_addr_o <= chk_start;
                  end_reg <= chk_end;
                  two_phase_reg <= chk_two;
                  tgt_flash_reg <= chk_flash;
                  tgt_ee_reg <= chk_ee;
                  // empty section and foreign commands end at once
                  if (chk_verify && chk_start != chk_end) begin
                     state_reg <= nev_pkg::ST_READ;
                  end else begin
                     state_reg <= nev_pkg::ST_DONE;
                  end
               end
            end
            nev_pkg::ST_READ: begin
               if (rd_i.valid) begin
                  if (!last_lw) begin
                     rd_addr_o <= addr_next;
                  end else if (two_phase_reg) begin // RQ7
                     two_phase_reg <= 1'b0;
                     rd_addr_o <= nev_pkg::EE_BASE;
                     end_reg <= nev_pkg::EE_END;
                  end else begin
                     state_reg <= nev_pkg::ST_DONE;
                  end
               end
            end
            nev_pkg::ST_DONE: begin
               state_reg <= nev_pkg::ST_IDLE;
               tgt_flash_reg <= 1'b0;
               tgt_ee_reg <= 1'b0;
            end
         endcase
      end
   end

   // read request stays up until the array answers the last longword
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_req_o <= 1'b0;
      end else if (launch && !chk_err && chk_verify &&
                   chk_start != chk_end) begin
         rd_req_o <= 1'b1;
      end else if (rd_done && last_lw && !two_phase_reg) begin
         rd_req_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         command_complete_flag_o <= 1'b1;
      end else if (launch && !chk_err) begin
         command_complete_flag_o <= 1'b0; // RQ8
      end else if (state_reg == nev_pkg::ST_DONE) begin
         command_complete_flag_o <= 1'b1; // RQ8
      end
   end

   // error set wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         access_error_flag_o <= 1'b0;
      end else if (launch && chk_err) begin
         access_error_flag_o <= 1'b1; // RQ1 RQ2 RQ14 RQ16
      end else if (err_clr_i) begin
         access_error_flag_o <= 1'b0;
      end
   end

   // verify commands never flag protection; other jobs own the set side
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         protection_violation_flag_o <= 1'b0;
      end else if (err_clr_i) begin
         protection_violation_flag_o <= 1'b0; // RQ10
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         verify_status_bits_o <= 2'h0;
      end else if (launch && !chk_err) begin
         verify_status_bits_o <= 2'h0;
      end else if (rd_done) begin
         if (rd_i.data != nev_pkg::ERASED_LW) begin
            verify_status_bits_o <= 2'h3; // RQ9 RQ13 RQ20
         end else begin
            verify_status_bits_o <= verify_status_bits_o |
                                    {rd_i.err, rd_i.uncorr}; // RQ10
         end
      end
   end

   // fault flags: hardware set wins over software clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         single_fault_detect_flag_o <= 1'b0;
         double_fault_detect_flag_o <= 1'b0;
      end else if (conflict) begin
         single_fault_detect_flag_o <= 1'b1; // RQ4
         double_fault_detect_flag_o <= 1'b1; // RQ4
      end else begin
         if (fault_clr_i[0]) single_fault_detect_flag_o <= 1'b0;
         if (fault_clr_i[1]) double_fault_detect_flag_o <= 1'b0;
      end
   end

   // flags are both set by the time the read data is returned
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_invalid_o <= 1'b0;
      end else begin
         cpu_invalid_o <= conflict; // RQ3
      end
   end

   AST_NODIV: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && nev_pkg::is_prog_erase(cob.cmd) && !div_init_i
      |=> access_error_flag_o && command_complete_flag_o) // RQ1
      else $error("program launch without divider not refused");

   AST_BADCMD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && !nev_pkg::is_valid_cmd(cob.cmd)
      |=> access_error_flag_o && state_reg == nev_pkg::ST_IDLE) // RQ2
      else $error("undefined command not refused");

   AST_INVALID: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      conflict |=> cpu_invalid_o && single_fault_detect_flag_o &&
                   double_fault_detect_flag_o) // RQ3
      else $error("busy block read not marked invalid");

   AST_FAULTSET: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      cpu_rd_i && state_reg == nev_pkg::ST_READ && tgt_flash_reg &&
      !cpu_addr_i[nev_pkg::SEL_BIT]
      |=> single_fault_detect_flag_o && double_fault_detect_flag_o) // RQ4
      else $error("fault flags not set on busy read");

   AST_ALLIDX: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && cob.cmd == nev_pkg::CMD_EV_ALL &&
      cob.index != nev_pkg::IDX_EV_ALL |=> access_error_flag_o) // RQ7
      else $error("all-blocks bad index not flagged");

   AST_COMMAND_COMPLETE_FLAG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && !chk_err && chk_verify && chk_start != chk_end
      |=> !command_complete_flag_o ##1 !command_complete_flag_o) // RQ8
      else $error("complete flag not held low after launch");

   AST_CCIFBUSY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      state_reg == nev_pkg::ST_READ |-> !command_complete_flag_o) // RQ8
      else $error("complete flag high during scan");

   AST_BLANK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      rd_done && rd_i.data != nev_pkg::ERASED_LW
      |=> verify_status_bits_o == 2'h3 [*2]) // RQ9
      else $error("blank check failure not reported");

   AST_RDERR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      rd_done && rd_i.err && rd_i.uncorr |=> verify_status_bits_o == 2'h3)
      else $error("read errors not reported"); // RQ10

   AST_NOPROT: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $rose(state_reg == nev_pkg::ST_READ) |-> !protection_violation_flag_o)
      else $error("protection flag during verify"); // RQ10

   AST_EESEL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && !chk_err && cob.cmd == nev_pkg::CMD_EV_BLK &&
      cob.addr[nev_pkg::SEL_BIT]
      |=> ##[0:1] rd_addr_o == nev_pkg::EE_BASE) // RQ12
      else $error("eeprom block not selected by address bit");

   AST_ALIGN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && cob.cmd == nev_pkg::CMD_EV_SECT && cob.addr[1:0] != 2'h0
      |=> access_error_flag_o && command_complete_flag_o) // RQ17
      else $error("unaligned section not refused");

   AST_SECTIDX: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && cob.cmd == nev_pkg::CMD_EV_SECT &&
      (cob.index != nev_pkg::IDX_EV_SECT || !mode_ok_i)
      |=> access_error_flag_o) // RQ16
      else $error("section index or mode not refused");

   AST_STEP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      rd_done && !last_lw |=> rd_addr_o == $past(rd_addr_o) + 24'h4)
      else $error("scan address did not step one longword"); // RQ20

   CVR_ALL: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && cob.cmd == nev_pkg::CMD_EV_ALL && !chk_err);
   CVR_BLK_FAIL: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      state_reg == nev_pkg::ST_DONE && verify_status_bits_o == 2'h3);
   CVR_SECT: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      launch && cob.cmd == nev_pkg::CMD_EV_SECT && !chk_err);
   CVR_FAULT: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      conflict);
endmodule : nev_sequencer

/* src/nev_pkg.sv */
// package for the erase-verify command sequencer: command codes,
// command object indices, nonvolatile address map, carriers, states.
// assumes all users refer to items as nev_pkg::name.
package nev_pkg;

   // command codes
   localparam logic [7:0] CMD_EV_ALL = 8'h01;
   localparam logic [7:0] CMD_EV_BLK = 8'h02;
   localparam logic [7:0] CMD_EV_SECT = 8'h03;

   // command object index expected at launch
   localparam logic [2:0] IDX_EV_ALL = 3'h0;
   localparam logic [2:0] IDX_EV_BLK = 3'h1;
   localparam logic [2:0] IDX_EV_SECT = 3'h2;
   localparam logic [2:0] IDX_RESET = 3'h0;

   // nonvolatile map, end addresses exclusive
   localparam logic [23:0] FLASH_BASE = 24'h00_0000;
   localparam logic [23:0] FLASH_END = 24'h00_2000;
   localparam logic [23:0] EE_BASE = 24'h80_0000;
   localparam logic [23:0] EE_END = 24'h80_0100;
   localparam int unsigned SEL_BIT = 23;
   localparam logic [23:0] LW_STEP = 24'h00_0004;
   localparam logic [31:0] ERASED_LW = 32'hffff_ffff;
   localparam logic [15:0] COB_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_DONE
   } nev_state_e;

   // launch parameters gathered from the command object
   typedef struct packed {
      logic [7:0] cmd;
      logic [23:0] addr;
      logic [15:0] count;
      logic [2:0] index;
   } nev_cob_s;

   // answer of the array read port
   typedef struct packed {
      logic valid;
      logic err;
      logic uncorr;
      logic [31:0] data;
   } nev_rd_s;

   function automatic logic is_valid_cmd(input logic [7:0] c);
      is_valid_cmd = (c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
         8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10,
         8'h11, 8'h12});
   endfunction : is_valid_cmd

   function automatic logic is_prog_erase(input logic [7:0] c);
      is_prog_erase = (c inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
         8'h0b, 8'h11, 8'h12});
   endfunction : is_prog_erase

endpackage : nev_pkg

/* src/nev_cmd_object.sv */
// command object storage: index register and eight high/low byte pairs.
// assumes writes come as single-cycle strobes on the system clock.
`timescale 1ns/1ns
module nev_cmd_object (
   input wire logic clk_i, // system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic lock_i, // high while a command runs
   input wire logic idx_wr_i, // write command_object_index
   input wire logic [2:0] idx_data_i, // new index value
   input wire logic hi_wr_i, // write command_object_high
   input wire logic lo_wr_i, // write command_object_low
   input wire logic [7:0] wdata_i, // byte written
   output logic [15:0] rdata_o, // pair at current index
   output nev_pkg::nev_cob_s cob_o // launch parameters
);
   logic [15:0] mem_reg [8];
   logic [2:0] idx_reg;

   // writes are ignored while a command runs
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idx_reg <= nev_pkg::IDX_RESET;
      end else if (idx_wr_i && !lock_i) begin
         idx_reg <= idx_data_i;
      end
   end

   for (genvar g = 0; g < 8; g++) begin : g_word
      always_ff @(posedge clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            mem_reg[g] <= nev_pkg::COB_RESET;
         end else if (!lock_i && idx_reg == 3'(g)) begin
            if (hi_wr_i) mem_reg[g][15:8] <= wdata_i; // RQ21
            if (lo_wr_i) mem_reg[g][7:0] <= wdata_i; // RQ21
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= nev_pkg::COB_RESET;
      end else begin
         rdata_o <= mem_reg[idx_reg]; // RQ21
      end
   end

   assign cob_o = '{cmd: mem_reg[0][15:8],
                    addr: {mem_reg[0][7:0], mem_reg[1]}, // RQ11 RQ15
                    count: mem_reg[2], // RQ15
                    index: idx_reg};
endmodule : nev_cmd_object

/* src/nev_launch_check.sv */
// launch checker: decides access error and scan range for a command.
// purely combinational; the caller samples it on the launch strobe.
`timescale 1ns/1ns
module nev_launch_check (
   input nev_pkg::nev_cob_s cob_i, // launch parameters
   input wire logic div_init_i, // clock divider initialised
   input wire logic mode_ok_i, // section verify allowed in mode
   output logic err_o, // launch must set access error
   output logic verify_o, // command is handled here
   output logic two_phase_o, // flash then eeprom
   output logic tgt_flash_o, // flash block busy
   output logic tgt_ee_o, // eeprom block busy
   output logic [23:0] start_o, // first longword address
   output logic [23:0] end_o // address after last longword
);
   logic in_flash;
   logic in_ee;
   logic [24:0] sect_end;

   assign in_flash = cob_i.addr >= nev_pkg::FLASH_BASE &&
                     cob_i.addr < nev_pkg::FLASH_END;
   assign in_ee = cob_i.addr >= nev_pkg::EE_BASE &&
                  cob_i.addr < nev_pkg::EE_END;
   assign sect_end = {1'b0, cob_i.addr} + {7'h00, cob_i.count, 2'h0};

   always_comb begin
      err_o = 1'b0;
      verify_o = 1'b1;
      two_phase_o = 1'b0;
      tgt_flash_o = 1'b1;
      tgt_ee_o = 1'b0;
      start_o = nev_pkg::FLASH_BASE;
      end_o = nev_pkg::FLASH_END;
      unique case (cob_i.cmd)
         nev_pkg::CMD_EV_ALL: begin
            err_o = cob_i.index != nev_pkg::IDX_EV_ALL; // RQ7
            two_phase_o = 1'b1;
            tgt_ee_o = 1'b1;
         end
         nev_pkg::CMD_EV_BLK: begin
            err_o = cob_i.index != nev_pkg::IDX_EV_BLK;
            if (cob_i.addr[nev_pkg::SEL_BIT]) begin // RQ12
               err_o = err_o || !in_ee; // RQ14
               tgt_flash_o = 1'b0;
               tgt_ee_o = 1'b1;
               start_o = nev_pkg::EE_BASE;
               end_o = nev_pkg::EE_END;
            end else begin
               err_o = err_o || !in_flash; // RQ14
            end
         end
         nev_pkg::CMD_EV_SECT: begin
            err_o = cob_i.index != nev_pkg::IDX_EV_SECT || // RQ16
                    !mode_ok_i || // RQ19
                    !in_flash || // RQ14
                    cob_i.addr[1:0] != 2'h0 || // RQ17
                    sect_end > {1'b0, nev_pkg::FLASH_END}; // RQ18
            start_o = cob_i.addr;
            end_o = sect_end[23:0];
         end
         default: begin
            verify_o = 1'b0;
            tgt_flash_o = 1'b0;
            err_o = !nev_pkg::is_valid_cmd(cob_i.cmd) || // RQ2
                    (nev_pkg::is_prog_erase(cob_i.cmd) &&
                     !div_init_i); // RQ1
         end
      endcase
   end
endmodule : nev_launch_check

/* testbench/nev_sequencer_tb.sv */
// self-checking bench for the erase-verify sequencer.
// assumes the bench plays the array: erased except at bad; erra and ue addresses answer with read errors.
`timescale 1ns/1ns
module nev_sequencer_tb;
   logic clk_i, arst_n_i, idx_wr_i, hi_wr_i, lo_wr_i, command_complete_flag_clr_i, hit;
   logic err_clr_i, div_init_i, mode_ok_i, cpu_rd_i, rd_req_o;
   logic cpu_invalid_o, ccf, aef, pvf, sff, dff;
   logic [2:0] idx_data_i;
   logic [7:0] cob_wdata_i;
   logic [15:0] cob_rdata_o;
   logic [1:0] fault_clr_i, vsb;
   logic [23:0] rd_addr_o, cpu_addr_i, bad, erra, ue;
   nev_pkg::nev_rd_s rd_i;
   int mismatches, n_tests, k;
   int unsigned seed = 5;
   int q[$];

   nev_sequencer dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .idx_wr_i(idx_wr_i), .idx_data_i(idx_data_i), .hi_wr_i(hi_wr_i),
      .lo_wr_i(lo_wr_i), .cob_wdata_i(cob_wdata_i),
      .cob_rdata_o(cob_rdata_o), .command_complete_flag_clr_i(command_complete_flag_clr_i),
      .err_clr_i(err_clr_i), .fault_clr_i(fault_clr_i),
      .div_init_i(div_init_i), .mode_ok_i(mode_ok_i), .rd_i(rd_i),
      .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .cpu_rd_i(cpu_rd_i),
      .cpu_addr_i(cpu_addr_i), .cpu_invalid_o(cpu_invalid_o),
      .command_complete_flag_o(ccf), .access_error_flag_o(aef),
      .protection_violation_flag_o(pvf), .verify_status_bits_o(vsb),
      .single_fault_detect_flag_o(sff), .double_fault_detect_flag_o(dff));

   function automatic int unsigned rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc

   // s selects strobe: 1 index, 2 high byte, 4 low byte
   // one idle cycle after each strobe so no strobe is re-driven at once
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      idx_data_i = d[2:0];
      cob_wdata_i = d;
      {lo_wr_i, hi_wr_i, idx_wr_i} = s;
      cyc(1);
      {lo_wr_i, hi_wr_i, idx_wr_i} = 3'b000;
      cyc(1);
   endtask : wr

   task automatic fill(input int lo, input int hi);
      for (int a = lo; a < hi; a += 4) q.push_back(a);
   endtask : fill

   task automatic run(input logic [7:0] c, input logic [23:0] a,
         input logic [15:0] n, input logic [2:0] x, input logic e,
         input logic [1:0] v);
      wr(3'h1, 8'h00);
      wr(3'h2, c);
      wr(3'h4, a[23:16]);
      wr(3'h1, 8'h01);
      wr(3'h2, a[15:8]);
      wr(3'h4, a[7:0]);
      wr(3'h1, 8'h02);
      wr(3'h2, n[15:8]);
      wr(3'h4, n[7:0]);
      cyc(2);
      chk(cob_rdata_o, n);
      wr(3'h1, {5'h00, x});
      if (!e && c == 8'h01) fill(0, 'h2000);
      hit = c == 8'h01 || (c == 8'h02 && a[23]);
      if (!e && hit) fill('h800000, 'h800100);
      if (!e && c == 8'h02 && !a[23]) fill(0, 'h2000);
      if (!e && c == 8'h03) fill(a, a + 4 * n);
      command_complete_flag_clr_i = 1'b1;
      cyc(1);
      command_complete_flag_clr_i = 1'b0;
      chk(aef, e);
      chk(ccf, e);
      if (e) begin
         err_clr_i = 1'b1;
         cyc(1);
         err_clr_i = 1'b0;
      end else begin
         k = rnd();
         cpu_addr_i = {k[0], 23'h000010};
         hit = k[0] ? hit : !(c == 8'h02 && a[23]);
         cpu_rd_i = 1'b1;
         cyc(1);
         cpu_rd_i = 1'b0;
         chk(cpu_invalid_o, hit);
         chk({sff, dff}, {hit, hit});
         fault_clr_i = 2'b11;
         cyc(1);
         fault_clr_i = 2'b00;
         for (k = 0; k < 20000 && ccf !== 1'b1; k++) cyc(1);
         chk(ccf, 1'b1);
         if (ccf !== 1'b1) finish_test();
         chk(q.size(), 0);
         chk(vsb, v);
         chk(pvf, 1'b0);
      end
   endtask : run

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // array model: random latency, one idle cycle after every answer
   always @(negedge clk_i) begin
      if (rd_i.valid || rd_req_o !== 1'b1 || rnd() % 3 == 0) begin
         rd_i.valid = 1'b0;
      end else begin
         chk({8'h00, rd_addr_o}, q.size() ? q.pop_front() : 32'hffffffff);
         rd_i.valid = 1'b1;
         rd_i.data = (rd_addr_o == bad) ? 32'h0000_0000 : nev_pkg::ERASED_LW;
         rd_i.err = (rd_addr_o == erra) || (rd_addr_o == ue);
         rd_i.uncorr = (rd_addr_o == ue);
      end
   end

   initial begin
      {arst_n_i, idx_wr_i, hi_wr_i, lo_wr_i, command_complete_flag_clr_i, err_clr_i} = '0;
      {div_init_i, mode_ok_i, cpu_rd_i, fault_clr_i} = '0;
      idx_data_i = 3'h0;
      cob_wdata_i = 8'h00;
      cpu_addr_i = 24'h000000;
      rd_i = '0;
      bad = 24'hffffff;
      erra = 24'hffffff;
      ue = 24'hffffff;
      mismatches = 0;
      n_tests = 0;
      // count rising edges: the first falling edge at time zero is not one
      repeat (3) @(posedge clk_i);
      cyc(1);
      arst_n_i = 1'b1;
      chk({ccf, aef, pvf, vsb, sff, dff}, 32'h40);
      run(8'h05, 24'h000000, 16'h0002, 3'h0, 1'b1, 2'b00);
      run(8'h06, 24'h000000, 16'h0002, 3'h3, 1'b1, 2'b00);
      div_init_i = 1'b1;
      run(8'h03, 24'h000100, 16'h0002, 3'h2, 1'b1, 2'b00);
      mode_ok_i = 1'b1;
      run(8'h01, 24'h000000, 16'h0000, 3'h1, 1'b1, 2'b00);
      run(8'h03, 24'h000100, 16'h0002, 3'h0, 1'b1, 2'b00);
      run(8'h03, 24'h000102, 16'h0002, 3'h2, 1'b1, 2'b00);
      run(8'h03, 24'h001ff8, 16'h0003, 3'h2, 1'b1, 2'b00);
      run(8'h02, 24'h400000, 16'h0000, 3'h1, 1'b1, 2'b00);
      bad = 24'h00017c;
      run(8'h03, 24'h000100, 16'h0020, 3'h2, 1'b0, 2'b11);
      run(8'h03, 24'h001ff8, 16'h0002, 3'h2, 1'b0, 2'b00);
      erra = 24'h001ffc;
      run(8'h03, 24'h001ff8, 16'h0002, 3'h2, 1'b0, 2'b10);
      erra = 24'hffffff;
      ue = 24'h000004;
      run(8'h03, 24'h000000, 16'h0002, 3'h2, 1'b0, 2'b11);
      ue = 24'hffffff;
      bad = 24'h8000fc;
      run(8'h02, 24'h800000, 16'h0000, 3'h1, 1'b0, 2'b11);
      run(8'h02, 24'h000000, 16'h0000, 3'h1, 1'b0, 2'b00);
      run(8'h01, 24'h000000, 16'h0000, 3'h0, 1'b0, 2'b11);
      bad = 24'hffffff;
      run(8'h01, 24'h000000, 16'h0000, 3'h0, 1'b0, 2'b00);
      finish_test();
   end
endmodule : nev_sequencer_tb
